// ### bench/fault_status_word_properties.sv
// assertion checker watching the status word ports
`timescale 1ns/1ps
module fault_status_word_properties (
  // clock, reset and register writes
  input wire logic        sys_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        reg_wr_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  // frame events, sources and the word
  input wire logic        frame_start_in,
  input wire logic        frame_end_in,
  input wire logic [3:0]  cmd_code_in,
  input wire logic        supply_any_in,
  input wire logic        timing_any_in,
  input wire logic        logic_any_in,
  input wire logic        overcurrent_any_in,
  input wire logic [15:0] status_word_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic wr_hit;
  assign wr_hit = reg_wr_in && reg_addr_in == 8'h01;
  a_supply_goes_low: assert property (supply_any_in |-> ##2 !status_word_out[14])
    else $error("supply summary not low");
  a_timing_goes_low: assert property (timing_any_in |-> ##2 !status_word_out[13])
    else $error("timing summary not low");
  a_logic_goes_low: assert property (logic_any_in |-> ##2 !status_word_out[12])
    else $error("logic summary not low");
  a_overcur_goes_low: assert property (overcurrent_any_in |-> ##2 !status_word_out[11])
    else $error("overcurrent summary not low");
  // a write shows in the word two cycles after its strobe, hence the past term
  a_summary_sticks: assert property (!status_word_out[14] && !$past(wr_hit) |=>
    !status_word_out[14]) else $error("supply summary released without write");
  a_reboot_cleared: assert property (wr_hit && reg_wdata_in[15] |-> ##2 status_word_out[15])
    else $error("reboot bit not restored");
  a_frame_clears: assert property (frame_start_in && !frame_end_in |->
    ##2 status_word_out[10:7] == 4'hf) else $error("frame errors not cleared");
  a_code_shown: assert property (frame_end_in |->
    ##2 status_word_out[6:3] == $past(cmd_code_in, 2)) else $error("response code wrong");
endmodule // fault_status_word_properties
bind fault_status_word fault_status_word_properties u_props (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .frame_start_in(frame_start_in),
  .frame_end_in(frame_end_in), .cmd_code_in(cmd_code_in), .supply_any_in(supply_any_in),
  .timing_any_in(timing_any_in), .logic_any_in(logic_any_in),
  .overcurrent_any_in(overcurrent_any_in), .status_word_out(status_word_out));

// ### bench/frame_engine_model.sv
// far-side frame engine model: register strobes and frame events
`timescale 1ns/1ps
module frame_engine_model (
  // clock
  input  wire logic   sys_clk_in,
  // register strobes
  output logic        reg_wr_out,
  output logic        reg_rd_out,
  output logic [7:0]  reg_addr_out,
  output logic [15:0] reg_wdata_out,
  // frame events
  output logic        frame_start_out,
  output logic        frame_end_out,
  output logic [2:0]  err_out,
  output logic [3:0]  cmd_code_out
);
  initial begin
    {reg_wr_out, reg_rd_out, frame_start_out, frame_end_out} = 4'h0;
    {reg_addr_out, reg_wdata_out, err_out, cmd_code_out} = 31'h0;
  end
  // idle lines show the inverse so a stale value never passes for a fresh one
  task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] data);
    @(posedge sys_clk_in);
    reg_wr_out <= wr;
    reg_rd_out <= ~wr;
    reg_addr_out <= addr;
    reg_wdata_out <= data;
    @(posedge sys_clk_in);
    {reg_wr_out, reg_rd_out} <= 2'h0;
    reg_addr_out <= ~addr;
    reg_wdata_out <= ~data;
  endtask
  task automatic frame_open();
    @(posedge sys_clk_in);
    frame_start_out <= 1'b1;
    @(posedge sys_clk_in);
    frame_start_out <= 1'b0;
  endtask
  task automatic frame_close(input logic [2:0] errs, input logic bad, input logic [3:0] code);
    @(posedge sys_clk_in);
    frame_end_out <= 1'b1;
    err_out <= errs;
    cmd_code_out <= code;
    reg_rd_out <= bad;
    reg_addr_out <= 8'hff;
    @(posedge sys_clk_in);
    {frame_end_out, reg_rd_out, err_out} <= 5'h0;
    reg_addr_out <= 8'h00;
    cmd_code_out <= ~code;
  endtask
endmodule // frame_engine_model

// ### bench/tb_top.sv
// self-checking bench for the primary status word
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        reg_wr, reg_rd, frame_start, frame_end, rd_valid, rd_hit;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, rd_data, status;
  logic [2:0]  err;
  logic [2:0]  lmc = 3'h0;
  logic [3:0]  cmd;
  logic [3:0]  src = 4'h0;
  int          n_fail = 0, checks = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  frame_engine_model u_host (.sys_clk_in(sys_clk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
    .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .frame_start_out(frame_start),
    .frame_end_out(frame_end), .err_out(err), .cmd_code_out(cmd));
  fault_status_word u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .rd_hit_out(rd_hit), .frame_start_in(frame_start),
    .frame_end_in(frame_end), .check_err_in(err[2]), .timeout_err_in(err[1]),
    .edge_count_err_in(err[0]), .cmd_code_in(cmd), .lock_in(lmc[2]), .clock_ind_in(lmc[1]),
    .mode_in(lmc[0]), .supply_any_in(src[3]), .timing_any_in(src[2]), .logic_any_in(src[1]),
    .overcurrent_any_in(src[0]), .status_word_out(status));
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  function automatic logic [15:0] word_exp(input logic [3:0] sum_n);
    return {1'b1, sum_n, 11'h7c8};
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    logic [2:0] e;
    logic       b;
    logic [3:0] c;
    void'($urandom(32'h71e3));
    repeat (3) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    step(1);
    cmp("reset word", 16'h7fc8, status);
    u_host.access(1'b0, 8'h01, 16'h0);
    step(0);
    cmp("read data", 16'h7fc8, rd_data);
    cmp("read hit", 16'h3, {14'h0, rd_valid, rd_hit});
    u_host.access(1'b0, 8'h02 + 8'($urandom % 253), 16'h0);
    step(0);
    cmp("unmapped data", 16'h0, rd_data);
    cmp("unmapped hit", 16'h2, {14'h0, rd_valid, rd_hit});
    u_host.access(1'b1, 8'h01, 16'h8000);
    step(1);
    cmp("reboot restored", 16'hffc8, status);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_in);
      src <= 4'h1 << i;
      step(3);
      cmp("summary set", word_exp(~(4'h1 << i)), status);
      u_host.access(1'b1, 8'h01, 16'hf800);
      step(1);
      cmp("source wins", word_exp(~(4'h1 << i)), status);
      @(posedge sys_clk_in);
      src <= 4'h0;
      step(3);
      cmp("summary sticky", word_exp(~(4'h1 << i)), status);
      u_host.access(1'b1, 8'h01, 16'hf800);
      step(1);
      cmp("summary released", 16'hffc8, status);
    end
    for (int k = 0; k < 8; k++) begin
      e = (k == 0) ? 3'h7 : 3'($urandom);
      b = (k == 0) ? 1'b1 : 1'($urandom);
      c = 4'($urandom);
      u_host.frame_open();
      lmc <= 3'($urandom);
      step(2);
      cmp("errors cleared", 16'hf, {12'h0, status[10:7]});
      u_host.frame_close(e, b, c);
      step(2);
      cmp("frame word", {5'h1f, ~{e, b}, c, lmc}, status);
    end
    // a second reset mid-run must bring back the reset flag and the first-frame code
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b1;
    step(1);
    cmp("word in reset", 16'h7fc8, status);
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    step(1);
    cmp("word after reset", 16'h7fc8 | {13'h0, lmc}, status);
    final_report;
  end
  // the sequence needs under 150 cycles; 5000 means a hang
  initial begin
    #40000;
    n_fail++;
    final_report;
  end
endmodule // tb_top

// ### src/fault_status_word.sv
// primary status word of the pack monitor: fault summaries, frame errors, response code
`timescale 1ns/1ps
`include "fault_status_word_map.svh"
// Contract
// RULE_01 - reboot bit 15 reads 0 after reset; writing 1 sets it to 1.
// RULE_02 - bit 14 goes low while any unmasked supply fault flag is set.
// RULE_03 - summary bits stick at 0; write 1 restores only once sources clear.
// RULE_04 - bit 13 goes low while any unmasked clock fault flag is set.
// RULE_05 - bit 12 goes low while any unmasked digital fault flag is set.
// RULE_06 - bit 11 goes low while any unmasked overcurrent flag is set.
// RULE_07 - bit 10 reads 0 after a frame with a check error.
// RULE_08 - bit 9 reads 0 after a frame that ended by timeout.
// RULE_09 - bit 8 reads 0 after a frame with wrong clock edge count.
// RULE_10 - bits 10 to 7 return to 1 at every new frame start; a frame end in the same cycle loads the ended frame's errors instead.
// RULE_11 - access to address FFh or above reports bit 7 low next frame.
// RULE_12 - status word sits at address 01h and resets to 7FC8h.
// RULE_13 - bits 6 to 3 show 1001b first, then the previous command's code.
module fault_status_word (
  // clock and reset
  input  wire logic                                sys_clk_in,
  input  wire logic                                sys_rst_in,
  // register access from the frame engine
  input  wire logic                                reg_wr_in,
  input  wire logic                                reg_rd_in,
  input  wire fault_status_word_pkg::reg_addr_type reg_addr_in,
  input  wire fault_status_word_pkg::status_word_type reg_wdata_in,
  output fault_status_word_pkg::status_word_type   rd_data_out,
  output logic                                     rd_valid_out,
  output logic                                     rd_hit_out,
  // frame events from the frame engine
  input  wire logic                                frame_start_in,
  input  wire logic                                frame_end_in,
  input  wire logic                                check_err_in,
  input  wire logic                                timeout_err_in,
  input  wire logic                                edge_count_err_in,
  input  wire fault_status_word_pkg::cmd_resp_type cmd_code_in,
  // device state shown in the low bits
  input  wire logic                                lock_in,
  input  wire logic                                clock_ind_in,
  input  wire logic                                mode_in,
  // unmasked source flags: supply, timing, logic, overcurrent alarm register
  input  wire logic                                supply_any_in,
  input  wire logic                                timing_any_in,
  input  wire logic                                logic_any_in,
  input  wire logic                                overcurrent_any_in,
  // status word for the frame engine to shift out
  output fault_status_word_pkg::status_word_type   status_word_out
);

  // carrier between this block and the per-frame error capture
  frame_err_if fe ();

  // register access state
  logic                                   rd_valid_ff;
  logic                                   nxt_rd_valid;
  logic                                   rd_hit_ff;
  logic                                   nxt_rd_hit;
  fault_status_word_pkg::status_word_type rd_data_ff;
  fault_status_word_pkg::status_word_type nxt_rd_data;
  logic                                   wr_hit;
  logic                                   bad_addr;
  logic                                   addr_hit;

  // sticky bits and captured indications
  logic                                   reboot_seen_n_ff;
  logic                                   nxt_reboot_seen_n;
  fault_status_word_pkg::summary_type     summary_n_ff;
  fault_status_word_pkg::summary_type     nxt_summary_n;
  fault_status_word_pkg::summary_type     source_any;
  fault_status_word_pkg::cmd_resp_type    cmd_resp_ff;
  fault_status_word_pkg::cmd_resp_type    nxt_cmd_resp;
  fault_status_word_pkg::status_word_type word_ff;
  fault_status_word_pkg::status_word_type nxt_word;

  // named views of the summary bits
  logic supply_alarm_summary_n;
  logic timing_alarm_summary_n;
  logic logic_alarm_summary_n;
  logic overcurrent_alarm_summary_n;

  // one address decode shared by the read and the write path
  assign addr_hit = (reg_addr_in == `FSW_ADDR); // RULE_12
  assign wr_hit   = reg_wr_in & addr_hit; // RULE_12
  // the address is eight bits wide, so only FFh is out of range here
  assign bad_addr = (reg_wr_in | reg_rd_in) & (reg_addr_in >= `FSW_BAD_ADDR_MIN); // RULE_11

  // a bad address rides to the capture block as a fourth per-frame error
  assign fe.frame_start = frame_start_in;
  assign fe.frame_end   = frame_end_in;
  assign fe.err_evt     = {check_err_in, timeout_err_in, edge_count_err_in, bad_addr};

  // errors of a frame are held back and shown from its end until the next start
  frame_error_capture u_capture (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .fe         (fe)
  );

  // order matches the summary bit positions 14 down to 11
  assign source_any = {supply_any_in, timing_any_in, logic_any_in, overcurrent_any_in};

  // only bits 15 to 11 are writable; zeros written to them change nothing
  // reboot flag: only a write of 1 lifts it, reset drops it
  always_comb begin
    nxt_reboot_seen_n = reboot_seen_n_ff;
    if (wr_hit && reg_wdata_in[`FSW_REBOOT_BIT]) begin
      nxt_reboot_seen_n = 1'b1; // RULE_01
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reboot_seen_n_ff <= 1'b0; // RULE_01
    end else begin
      reboot_seen_n_ff <= nxt_reboot_seen_n;
    end
  end

  // summaries: an active source wins over a write of 1 in the same cycle
  // a source still high keeps its bit low however often the host writes
  genvar s;
  generate
    for (s = 0; s < `FSW_SUMMARIES; s = s + 1) begin : g_sum
      always_comb begin
        nxt_summary_n[s] = summary_n_ff[s];
        if (source_any[s]) begin
          nxt_summary_n[s] = 1'b0; // RULE_02 RULE_04 RULE_05 RULE_06
        end else if (wr_hit && reg_wdata_in[`FSW_SUMMARY_LSB + s]) begin
          nxt_summary_n[s] = 1'b1; // RULE_03
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      summary_n_ff <= 4'hf;
    end else begin
      summary_n_ff <= nxt_summary_n;
    end
  end

  assign supply_alarm_summary_n      = summary_n_ff[3];
  assign timing_alarm_summary_n      = summary_n_ff[2];
  assign logic_alarm_summary_n       = summary_n_ff[1];
  assign overcurrent_alarm_summary_n = summary_n_ff[0];

  // response code of the frame just ended is what the next frame reports
  // until the first frame after reset ends, the reset code stays in place
  always_comb begin
    nxt_cmd_resp = cmd_resp_ff;
    if (frame_end_in) begin
      nxt_cmd_resp = cmd_code_in; // RULE_13
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd_resp_ff <= `FSW_CMD_RESET; // RULE_13
    end else begin
      cmd_resp_ff <= nxt_cmd_resp;
    end
  end

  // assembled word is registered, so it trails its fields by one cycle
  always_comb begin
    // each field placed by its own position, so one field cannot shift its neighbours
    nxt_word                                  = 16'h0000;
    nxt_word[`FSW_REBOOT_BIT]                 = reboot_seen_n_ff; // RULE_01
    nxt_word[`FSW_SUPPLY_BIT]                 = supply_alarm_summary_n; // RULE_02
    nxt_word[`FSW_TIMING_BIT]                 = timing_alarm_summary_n; // RULE_04
    nxt_word[`FSW_LOGIC_BIT]                  = logic_alarm_summary_n; // RULE_05
    nxt_word[`FSW_OVERCUR_BIT]                = overcurrent_alarm_summary_n; // RULE_06
    nxt_word[`FSW_CHECK_BIT:`FSW_FRAME_LSB]   = fe.err_n; // RULE_10
    nxt_word[`FSW_CMD_LSB +: 4]               = cmd_resp_ff; // RULE_13
    nxt_word[`FSW_LOCK_BIT]                   = lock_in;
    nxt_word[`FSW_CLOCK_BIT]                  = clock_ind_in;
    nxt_word[`FSW_MODE_BIT]                   = mode_in;
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      word_ff <= `FSW_RESET; // RULE_12
    end else begin
      word_ff <= nxt_word;
    end
  end

  // read answer one cycle after the strobe; other addresses answer zero and no hit
  // a read of FFh answers zero here and is flagged for the frame as well
  always_comb begin
    nxt_rd_valid = reg_rd_in;
    nxt_rd_hit   = 1'b0;
    nxt_rd_data  = rd_data_ff;
    if (reg_rd_in) begin
      if (addr_hit) begin
        nxt_rd_hit  = 1'b1; // RULE_12
        nxt_rd_data = word_ff;
      end else begin
        nxt_rd_data = 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_valid_ff <= 1'b0;
      rd_hit_ff   <= 1'b0;
      rd_data_ff  <= 16'h0000;
    end else begin
      rd_valid_ff <= nxt_rd_valid;
      rd_hit_ff   <= nxt_rd_hit;
      rd_data_ff  <= nxt_rd_data;
    end
  end

  // outputs come straight from the registers, nothing after them
  assign rd_valid_out    = rd_valid_ff;
  assign rd_hit_out      = rd_hit_ff;
  assign rd_data_out     = rd_data_ff;
  assign status_word_out = word_ff;

endmodule // fault_status_word

// ### src/fault_status_word_map.svh
// register offsets, field positions, reset values of the primary status word
`ifndef FAULT_STATUS_WORD_MAP_SVH
`define FAULT_STATUS_WORD_MAP_SVH

`define FSW_ADDR          8'h01
`define FSW_BAD_ADDR_MIN  8'hff
`define FSW_RESET         16'h7fc8

`define FSW_REBOOT_BIT    15
`define FSW_SUPPLY_BIT    14
`define FSW_TIMING_BIT    13
`define FSW_LOGIC_BIT     12
`define FSW_OVERCUR_BIT   11
`define FSW_SUMMARY_LSB   11
`define FSW_CHECK_BIT     10
`define FSW_TIMEOUT_BIT   9
`define FSW_EDGE_BIT      8
`define FSW_BADADDR_BIT   7
`define FSW_FRAME_LSB     7
`define FSW_CMD_LSB       3
`define FSW_LOCK_BIT      2
`define FSW_CLOCK_BIT     1
`define FSW_MODE_BIT      0

`define FSW_CMD_RESET     4'h9
`define FSW_FRAME_ERRS    4
`define FSW_SUMMARIES     4

`endif

// ### src/fault_status_word_pkg.sv
// types shared by the status word modules
package fault_status_word_pkg;
  typedef logic [15:0] status_word_type;
  typedef logic [7:0]  reg_addr_type;
  typedef logic [3:0]  cmd_resp_type;
  // index 3 check error, 2 timeout, 1 edge count, 0 bad address
  typedef logic [3:0]  frame_err_type;
  typedef logic [3:0]  summary_type;
endpackage

// ### src/frame_err_if.sv
// frame events and per-frame error flags passed between top and capture logic
`timescale 1ns/1ps
interface frame_err_if;
  logic                                frame_start;
  logic                                frame_end;
  fault_status_word_pkg::frame_err_type err_evt;
  fault_status_word_pkg::frame_err_type err_n;

  modport src (output frame_start, output frame_end, output err_evt, input err_n);
  modport cap (input frame_start, input frame_end, input err_evt, output err_n);
endinterface

// ### src/frame_error_capture.sv
// per-frame error capture: collects errors in a frame, shows them in the next
`timescale 1ns/1ps
`include "fault_status_word_map.svh"
module frame_error_capture (
  // clock and reset
  input  wire logic  sys_clk_in,
  input  wire logic  sys_rst_in,
  // frame events and flags
  frame_err_if.cap   fe
);

  fault_status_word_pkg::frame_err_type pend_n_ff;
  fault_status_word_pkg::frame_err_type nxt_pend_n;
  fault_status_word_pkg::frame_err_type shown_n_ff;
  fault_status_word_pkg::frame_err_type nxt_shown_n;

  genvar i;
  generate
    for (i = 0; i < `FSW_FRAME_ERRS; i = i + 1) begin : g_bit
      // an error in the same cycle as a frame end still counts for the ending frame
      always_comb begin
        nxt_pend_n[i]  = pend_n_ff[i];
        nxt_shown_n[i] = shown_n_ff[i];
        if (fe.frame_start) begin
          nxt_pend_n[i]  = 1'b1; // RULE_10
          nxt_shown_n[i] = 1'b1; // RULE_10
        end
        if (fe.err_evt[i]) begin
          nxt_pend_n[i] = 1'b0;
        end
        if (fe.frame_end) begin
          nxt_shown_n[i] = pend_n_ff[i] & ~fe.err_evt[i]; // RULE_07 RULE_08 RULE_09 RULE_11
          nxt_pend_n[i]  = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_n_ff  <= 4'hf;
      shown_n_ff <= 4'hf;
    end else begin
      pend_n_ff  <= nxt_pend_n;
      shown_n_ff <= nxt_shown_n;
    end
  end

  assign fe.err_n = shown_n_ff;

endmodule // frame_error_capture
